// >>> rtl/pss_top.v
// startup sequencing, pwm latch and soft-start of the controller
//
// Function
// [R1] the first oscillator pulse of each switching cycle, with pwm comparator low, sets gate drive on
// [R2] pwm comparator high turns gate drive off for the rest of cycle
// [R3] current-limit comparator high ends the on-cycle regardless of pwm
// [R4] nothing runs until enable threshold input reads above 1.23V
// [R5] during lockout, comparators, oscillator gating and driver stay disabled
// [R6] bootstrap variant needs supply above 21.6V to enable switching
// [R7] non-bootstrap variant starts at supply above 9.5V and enable high
// [R8] bootstrap variant drops to lockout when supply falls below 9.74V
// [R9] after bootstrap lockout, full startup with fresh soft-start repeats
// [R10] enable falling below 1.17V keeps switching 210us, then stops
// [R11] flag is released while enable high, pulled low at once when low
// [R12] flag follows only the enable input, never the supply lockout
// [R13] soft-start begins only when all lockout conditions are released
// [R14] reference climbs 0 to full scale over 1984 switching cycles
// [R15] half-rate variant: fsw = fosc/2, on-time at most 50%
// [R16] quarter-rate variant: fsw = fosc/4, on-time at most 75%
// [R17] variant and divide are parameters; thresholds enter synchronised
`timescale 1ns/1ps
`include "pss_map.vh"

module pss_top #(
	parameter BOOTSTRAP   = 1,
	parameter DIVIDE      = `PSS_DIV_HALF,
	parameter SHUTDOWN_CY = `PSS_SHUTDOWN_CYCLES
) (
	// clock and reset
	input  wire                  CLOCK,
	input  wire                  SYS_RST,
	// oscillator pulse, one cycle per oscillator period
	input  wire                  OSC_PULSE,
	// comparator results from the analog side
	input  wire                  ENABLE_ABOVE,
	input  wire                  SUPPLY_ABOVE_START,
	input  wire                  SUPPLY_ABOVE_BOOT_HI,
	input  wire                  SUPPLY_ABOVE_BOOT_LO,
	input  wire                  PWM_COMPARATOR,
	input  wire                  CURRENT_LIMIT_COMPARATOR,
	// outputs
	output reg                   GATE_DRIVE_OUT,
	output wire                  UNDERVOLTAGE_FLAG_OUT,
	output wire                  UNDERVOLTAGE_FLAG_OE_N,
	output wire                  OSC_ENABLE,
	output wire                  COMPARATOR_ENABLE,
	output reg  [`PSS_REF_W-1:0] SOFTSTART_REF,
	output reg  [1:0]            LOCKOUT_STATE
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	wire en_s;
	wire sup_start_s;
	wire boot_hi_s;
	wire boot_lo_s;
	wire pwm_s;
	wire current_limit_comparator_s;
	// every comparator result is asynchronous to the clock, so each one
	// passes two flops; the oscillator tick is already on this clock
	wire [5:0] raw_in = {ENABLE_ABOVE, SUPPLY_ABOVE_START, SUPPLY_ABOVE_BOOT_HI,
		SUPPLY_ABOVE_BOOT_LO, PWM_COMPARATOR, CURRENT_LIMIT_COMPARATOR};
	wire [5:0] sync_out;
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
			pss_sync u_sync (
				.clk  (CLOCK),
				.rst  (SYS_RST),
				.din  (raw_in[gi]),
				.dout (sync_out[gi])
			); // [R17]
		end
	endgenerate
	assign {en_s, sup_start_s, boot_hi_s, boot_lo_s, pwm_s, current_limit_comparator_s} = sync_out;

	// ------------------------------------------------------------
	// supply lockout
	// ------------------------------------------------------------
	// hysteresis lives in the two analog thresholds; a latch holds between them
	reg  boot_ok;
	wire supply_ok = (BOOTSTRAP != 0) ? boot_ok : sup_start_s; // [R7]

	always @(posedge CLOCK) begin
		if (SYS_RST)
			boot_ok <= 1'b0;
		else if (!boot_lo_s)
			boot_ok <= 1'b0; // [R8]
		else if (boot_hi_s && sup_start_s)
			boot_ok <= 1'b1; // [R6]
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// 16 bits hold the default delay; a longer delay needs a wider counter
	localparam SHD_W = 16;
	localparam integer SHD_LAST_I  = SHUTDOWN_CY - 1;
	localparam integer STEP_LAST_I = `PSS_SS_CYC_PER_STEP - 1;
	localparam integer REF_TOP_I   = `PSS_SS_STEPS;
	// integer results cut to the counter widths on purpose
	localparam [SHD_W-1:0]      SHD_LAST  = SHD_LAST_I[SHD_W-1:0];
	localparam [5:0]            STEP_LAST = STEP_LAST_I[5:0];
	localparam [`PSS_REF_W-1:0] REF_TOP   = REF_TOP_I[`PSS_REF_W-1:0];

	reg [SHD_W-1:0] shd_cnt;
	reg [5:0]       step_cnt;
	reg [1:0]       next_state;
	wire            running = (LOCKOUT_STATE == `PSS_ST_SOFTSTART) ||
	                          (LOCKOUT_STATE == `PSS_ST_RUN) ||
	                          (LOCKOUT_STATE == `PSS_ST_SHUTDOWN);
	wire            sw_end;

	// supply loss drops straight to lockout with no delay; enable loss
	// runs the shutdown delay first so the flag leads the driver stop
	always @* begin
		next_state = LOCKOUT_STATE;
		case (LOCKOUT_STATE)
			`PSS_ST_LOCKOUT: begin
				if (en_s && supply_ok)
					next_state = `PSS_ST_SOFTSTART; // [R4] [R13]
			end
			`PSS_ST_SOFTSTART, `PSS_ST_RUN: begin
				if (!supply_ok)
					next_state = `PSS_ST_LOCKOUT; // [R8] [R9]
				else if (!en_s)
					next_state = `PSS_ST_SHUTDOWN;
				else if (LOCKOUT_STATE == `PSS_ST_SOFTSTART && SOFTSTART_REF == REF_TOP)
					next_state = `PSS_ST_RUN;
			end
			`PSS_ST_SHUTDOWN: begin
				if (!supply_ok || shd_cnt == SHD_LAST)
					next_state = `PSS_ST_LOCKOUT; // [R10]
			end
			default: next_state = `PSS_ST_LOCKOUT;
		endcase
	end

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			LOCKOUT_STATE <= `PSS_ST_LOCKOUT;
			shd_cnt       <= {SHD_W{1'b0}};
			step_cnt      <= 6'h00;
			SOFTSTART_REF <= {`PSS_REF_W{1'b0}};
		end else begin
			LOCKOUT_STATE <= next_state;
			if (LOCKOUT_STATE == `PSS_ST_SHUTDOWN)
				shd_cnt <= shd_cnt + 1'b1; // [R10]
			else
				shd_cnt <= {SHD_W{1'b0}};
			// each lockout restarts the ramp from zero
			if (LOCKOUT_STATE == `PSS_ST_LOCKOUT) begin
				step_cnt      <= 6'h00;
				SOFTSTART_REF <= {`PSS_REF_W{1'b0}}; // [R9]
			end else if (sw_end && SOFTSTART_REF != REF_TOP) begin
				// 31 steps of 64 cycles give the 1984-cycle staircase
				if (step_cnt == STEP_LAST) begin
					step_cnt      <= 6'h00;
					SOFTSTART_REF <= SOFTSTART_REF + 1'b1; // [R14]
				end else begin
					step_cnt <= step_cnt + 1'b1; // [R14]
				end
			end
		end
	end

	assign OSC_ENABLE        = running; // [R5]
	assign COMPARATOR_ENABLE = running; // [R5]

	// ------------------------------------------------------------
	// oscillator divider and pwm latch
	// ------------------------------------------------------------
	reg  [1:0] phase;
	wire [1:0] phase_last = (DIVIDE == `PSS_DIV_QUARTER) ? 2'h3 : 2'h1;
	wire       sw_start   = running && OSC_PULSE && (phase == 2'h0);
	wire       max_duty   = running && OSC_PULSE && (phase == phase_last); // [R15] [R16]
	assign     sw_end     = max_duty;

	// the phase only advances while running, so every start opens with
	// a full on-phase rather than a leftover fraction of a period
	always @(posedge CLOCK) begin
		if (SYS_RST || !running)
			phase <= 2'h0;
		else if (OSC_PULSE)
			phase <= (phase == phase_last) ? 2'h0 : phase + 1'b1; // [R15] [R16]
	end

	// off causes outrank the set, so a tick that meets an active
	// comparator never opens a pulse; comparators reach the latch
	// two clocks late, which bounds how short a pulse can be
	always @(posedge CLOCK) begin
		if (SYS_RST || !running)
			GATE_DRIVE_OUT <= 1'b0; // [R5]
		else if (current_limit_comparator_s)
			GATE_DRIVE_OUT <= 1'b0; // [R3]
		else if (pwm_s)
			GATE_DRIVE_OUT <= 1'b0; // [R2]
		else if (max_duty)
			GATE_DRIVE_OUT <= 1'b0; // [R15] [R16]
		else if (sw_start)
			GATE_DRIVE_OUT <= 1'b1; // [R1]
	end

	// ------------------------------------------------------------
	// open-drain undervoltage flag
	// ------------------------------------------------------------
	// enable only, so the secondary side sees it ahead of the 210us stop
	assign UNDERVOLTAGE_FLAG_OUT  = 1'b0;
	assign UNDERVOLTAGE_FLAG_OE_N = en_s; // [R11] [R12]
endmodule // pss_top

// >>> common/pss_map.vh
// constants for the pwm startup sequencer
`ifndef PSS_MAP_VH
`define PSS_MAP_VH

`define PSS_CLK_PERIOD_NS   10
`define PSS_SHUTDOWN_DLY_NS 210000
`define PSS_SHUTDOWN_CYCLES (`PSS_SHUTDOWN_DLY_NS / `PSS_CLK_PERIOD_NS)
`define PSS_SS_CYCLES       1984
`define PSS_SS_STEPS        31
`define PSS_SS_CYC_PER_STEP 64
`define PSS_REF_W           5
`define PSS_DIV_HALF        2
`define PSS_DIV_QUARTER     4

`define PSS_ST_LOCKOUT      2'h0
`define PSS_ST_SOFTSTART    2'h1
`define PSS_ST_RUN          2'h2
`define PSS_ST_SHUTDOWN     2'h3

`endif

// >>> rtl/pss_sync.v
// two-flop synchroniser for one comparator result
`timescale 1ns/1ps
module pss_sync (
	// clock and reset
	input  wire clk,
	input  wire rst,
	// data
	input  wire din,
	output reg  dout
);
	reg meta;

	always @(posedge clk) begin
		if (rst) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // pss_sync

// >>> tb/pss_plant.sv
// oscillator ticks and switch current ramp
`timescale 1ns/1ps
module pss_plant #(parameter PER = 8, parameter RAMP = 2) (
	input  wire clk,
	input  wire gate,
	input  wire slow,
	output reg  osc_pulse,
	output wire pwm_high
);
	reg [7:0] tick = 8'h00;
	reg [7:0] ramp = 8'h00;
	initial osc_pulse = 1'b0;
	always @(posedge clk) begin
		tick <= (tick == PER - 1) ? 8'h00 : tick + 8'h01;
		osc_pulse <= #1 tick == PER - 1;
		ramp <= #1 gate ? ramp + 8'h01 : 8'h00;
	end
	// slow load never trips, so the duty limit ends each pulse
	assign pwm_high = !slow && ramp >= RAMP;
endmodule // pss_plant

// >>> tb/pss_chk_asserts.sv
// port assertions for the sequencer
`timescale 1ns/1ps
module pss_chk #(parameter DIVIDE = 2) (
	input wire       CLOCK,
	input wire       SYS_RST,
	input wire       OSC_PULSE,
	input wire       ENABLE_ABOVE,
	input wire       PWM_COMPARATOR,
	input wire       CURRENT_LIMIT_COMPARATOR,
	input wire       GATE_DRIVE_OUT,
	input wire       UNDERVOLTAGE_FLAG_OE_N,
	input wire       OSC_ENABLE,
	input wire       COMPARATOR_ENABLE,
	input wire [4:0] SOFTSTART_REF,
	input wire [1:0] LOCKOUT_STATE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	property p_lock; LOCKOUT_STATE == 2'h0 |-> !OSC_ENABLE && !COMPARATOR_ENABLE
		##1 !GATE_DRIVE_OUT; endproperty
	a_lock: assert property (p_lock) else $error("active in lockout");
	property p_set; $rose(GATE_DRIVE_OUT) |-> $past(OSC_PULSE); endproperty
	a_set: assert property (p_set) else $error("gate rose without tick");
	property p_pwm; PWM_COMPARATOR[*4] |-> !GATE_DRIVE_OUT; endproperty
	a_pwm: assert property (p_pwm) else $error("gate on past pwm");
	property p_current_limit_comparator; CURRENT_LIMIT_COMPARATOR[*4] |-> !GATE_DRIVE_OUT; endproperty
	a_current_limit_comparator: assert property (p_current_limit_comparator) else $error("gate on past limit");
	property p_fhi; ENABLE_ABOVE[*4] |-> UNDERVOLTAGE_FLAG_OE_N; endproperty
	a_fhi: assert property (p_fhi) else $error("flag held low");
	property p_flo; !ENABLE_ABOVE[*4] |-> !UNDERVOLTAGE_FLAG_OE_N; endproperty
	a_flo: assert property (p_flo) else $error("flag released");
	property p_ref; $changed(SOFTSTART_REF) |-> SOFTSTART_REF == 5'h00
		|| SOFTSTART_REF == $past(SOFTSTART_REF) + 5'h01; endproperty
	a_ref: assert property (p_ref) else $error("reference jumped");
	property p_duty; DIVIDE == 2 && OSC_PULSE && GATE_DRIVE_OUT |=> !GATE_DRIVE_OUT; endproperty
	a_duty: assert property (p_duty) else $error("duty limit missed");
endmodule // pss_chk
bind pss_top pss_chk #(.DIVIDE(DIVIDE)) u_pss_chk (.*);

// >>> tb/tb_pss_top.sv
// bench for the pwm startup sequencer
`timescale 1ns/1ps
module tb_pss_top;
	reg        clk = 0, rst = 1, en = 0, sst = 0, bhi = 0, blo = 0, il = 0, slow = 0;
	wire       osc, pwm, gate, oe_n;
	wire [4:0] rf;
	wire [1:0] st;
	integer    errors = 0, checks_done = 0, n, k, hi, hq;
	wire       gate_q, pwm_q, osc_q, fo, oen;
	wire [1:0] st_q;
	pss_plant u_pss_plant (.clk(clk), .gate(gate), .slow(slow), .osc_pulse(osc), .pwm_high(pwm));
	pss_plant u_pss_plant_quarter (.clk(clk), .gate(gate_q), .slow(1'b1), .osc_pulse(osc_q),
		.pwm_high(pwm_q));
	pss_top #(.BOOTSTRAP(0), .DIVIDE(4), .SHUTDOWN_CY(50)) u_pss_top_quarter (.CLOCK(clk),
		.SYS_RST(rst), .OSC_PULSE(osc_q), .ENABLE_ABOVE(en), .SUPPLY_ABOVE_START(sst),
		.SUPPLY_ABOVE_BOOT_HI(bhi), .SUPPLY_ABOVE_BOOT_LO(blo), .PWM_COMPARATOR(pwm_q),
		.CURRENT_LIMIT_COMPARATOR(il), .GATE_DRIVE_OUT(gate_q), .UNDERVOLTAGE_FLAG_OUT(),
		.UNDERVOLTAGE_FLAG_OE_N(), .OSC_ENABLE(), .COMPARATOR_ENABLE(), .SOFTSTART_REF(),
		.LOCKOUT_STATE(st_q));
	pss_top #(.SHUTDOWN_CY(50)) u_pss_top (.CLOCK(clk), .SYS_RST(rst), .OSC_PULSE(osc),
		.ENABLE_ABOVE(en), .SUPPLY_ABOVE_START(sst), .SUPPLY_ABOVE_BOOT_HI(bhi),
		.SUPPLY_ABOVE_BOOT_LO(blo), .PWM_COMPARATOR(pwm), .CURRENT_LIMIT_COMPARATOR(il),
		.GATE_DRIVE_OUT(gate), .UNDERVOLTAGE_FLAG_OUT(fo), .UNDERVOLTAGE_FLAG_OE_N(oe_n),
		.OSC_ENABLE(oen), .COMPARATOR_ENABLE(), .SOFTSTART_REF(rf), .LOCKOUT_STATE(st));
	task check(input string w, input logic [7:0] seen, input logic [7:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("mismatch %s expected %h seen %h", w, exp, seen);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task wait_st(input logic [1:0] s, input integer lim);
		for (n = 0; n < lim && st !== s; n = n + 1)
			cyc(1);
		check("state", {6'h00, st}, {6'h00, s});
	endtask
	initial forever #5 clk = ~clk;
	initial begin
		#500000;
		errors = errors + 1;
		close_out;
	end
	// counts gate-high samples of both instances over a span of cycles
	task count_high(input integer span);
		hi = 0;
		hq = 0;
		for (k = 0; k < span; k = k + 1) begin
			hi = hi + gate;
			hq = hq + gate_q;
			cyc(1);
		end
	endtask
	task t_lockout;
		cyc(2);
		rst = 0;
		en = 1;
		sst = 1;
		blo = 1;
		cyc(20);
		check("no boot", {6'h00, st}, 8'h00);
		check("quarter start", {6'h00, st_q}, 8'h01);
		check("flag data", {7'h00, fo}, 8'h00);
		check("osc off", {7'h00, oen}, 8'h00);
		en = 0;
		bhi = 1;
		cyc(20);
		check("no enable", {6'h00, st}, 8'h00);
		$display("lockout done");
	endtask
	task t_startup;
		en = 1;
		wait_st(2'h1, 10);
		check("ref low", {3'h0, rf}, 8'h00);
		wait_st(2'h2, 40000);
		check("ref top", {3'h0, rf}, 8'h1f);
		check("osc on", {7'h00, oen}, 8'h01);
		$display("startup done");
	endtask
	task t_duty;
		count_high(32);
		check("pwm pulse", hi[7:0], 8'd10);
		check("quarter duty", hq[7:0], 8'd24);
		slow = 1;
		cyc(40);
		count_high(32);
		check("half duty", hi[7:0], 8'd16);
		$display("duty done");
	endtask
	task t_limit;
		il = 1;
		cyc(3);
		count_high(32);
		check("limit", hi[7:0], 8'h00);
		check("limit quarter", hq[7:0], 8'h00);
		il = 0;
		$display("limit done");
	endtask
	task t_shutdown;
		en = 0;
		cyc(3);
		check("flag", {7'h00, oe_n}, 8'h00);
		wait_st(2'h3, 5);
		for (n = 0; n < 200 && st === 2'h3; n = n + 1)
			cyc(1);
		check("delay", n[7:0], 8'd50);
		$display("shutdown done");
	endtask
	task t_restart;
		en = 1;
		cyc(1100);
		bhi = 0;
		blo = 0;
		wait_st(2'h0, 5);
		check("flag kept", {7'h00, oe_n}, 8'h01);
		blo = 1;
		bhi = 1;
		wait_st(2'h1, 10);
		check("ref fresh", {3'h0, rf}, 8'h00);
		$display("restart done");
	endtask
	initial begin
		t_lockout;
		t_startup;
		t_duty;
		t_limit;
		t_shutdown;
		t_restart;
		close_out;
	end
endmodule // tb_pss_top
